//--- stlc_pkg.sv
// Constants, carrier structs and state layout of the system time loop control block.
// Assumes both access ports run on the block's own clock.
package stlc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] STLC_RX_TRIG_ADDR = 16'h0900;
  localparam logic [15:0] STLC_SYS_TIME_ADDR = 16'h0910;
  localparam logic [15:0] STLC_RX_EPU_ADDR = 16'h0918;
  localparam logic [15:0] STLC_OFFSET_ADDR = 16'h0920;
  localparam logic [15:0] STLC_DELAY_ADDR = 16'h0928;
  localparam logic [15:0] STLC_DIFF_ADDR = 16'h092C;
  localparam logic [15:0] STLC_START_ADDR = 16'h0930;
  localparam logic [15:0] STLC_SPD_ADDR = 16'h0932;
  localparam logic [15:0] STLC_DEPTH_ADDR = 16'h0934;
  localparam logic [2:0] STLC_SYS_LAST_WR_BYTE = 3'h3;
  localparam logic [15:0] STLC_SPD_MARGIN = 16'h007F;
  localparam logic [15:0] STLC_START_RESET = 16'h1000;
  localparam logic [63:0] STLC_TIME_RESET = 64'h0;
  localparam int STLC_CLK_MHZ = 125;
  localparam int STLC_CLK_PERIOD_NS = 1000 / STLC_CLK_MHZ;
  localparam logic [63:0] STLC_TIME_STEP = 64'(STLC_CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } stlc_bus_t;

  typedef struct packed {
    logic preamble;
    logic sof;
    logic eof;
  } stlc_frame_t;

  typedef struct packed {
    logic [63:0] local_time;
    logic [63:0] drift;
    logic [63:0] sof_snap;
    logic [63:0] host_snap;
    logic [63:0] pre_time;
    logic [63:0] rx_stamp;
    logic rx_pending;
    logic [63:0] offset;
    logic [31:0] delay;
    logic [31:0] net_wbuf;
    logic net_lowb;
    logic [31:0] host_wbuf;
    logic signed [31:0] filt;
    logic [14:0] start;
    logic signed [15:0] spd;
    logic [3:0] depth;
    logic [15:0] corr_cnt;
    logic [7:0] net_rdata;
    logic [7:0] host_rdata;
  } stlc_state_t;
endpackage

//--- stlc_time_loop.sv
// System time loop control: local system time copy, offset/delay, difference filter, speed counter.
// Assumes the frame engine and host interface deliver byte accesses and frame marks on clk_i.
//
// Contract
// - Host read snapshots time at lowest byte
// - Network low-byte write compared at frame end
// - Host top-byte write compared with capture 0
// - Host writes only with host control configured
// - Record preamble time of trigger-writing frames
// - Port 0 open: stamp equals port 0
// - Offset added to local time
// - Propagation delay added for network reads
// - Difference read as sign and magnitude
// - Start value sets loop bandwidth
// - Start write clears difference and speed
// - Speed difference clamped to start minus constant
// - Depth sets averaging; write clears difference
`timescale 1ns/1ns
`default_nettype none
module stlc_time_loop (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic host_ctrl_en_i,
  input wire stlc_pkg::stlc_frame_t frame_i,
  input wire stlc_pkg::stlc_bus_t net_i,
  input wire stlc_pkg::stlc_bus_t host_i,
  input wire logic [31:0] capture0_stamp_i,
  output logic [7:0] net_rdata_o,
  output logic [7:0] host_rdata_o
);
  import stlc_pkg::*;

  stlc_state_t s;
  stlc_state_t next_s;
  logic [63:0] sys_now;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] base, input logic [15:0] n);
    in_rng = (a >= base) && (a < base + n);
  endfunction

  function automatic logic [63:0] set_byte(input logic [63:0] v, input logic [2:0] i, input logic [7:0] b);
    logic [63:0] r;
    r = v;
    r[8*i +: 8] = b;
    set_byte = r;
  endfunction

  function automatic logic [31:0] diff_read(input logic signed [31:0] f);
    logic [31:0] mag;
    mag = f[31] ? 32'(-f) : 32'(f);
    diff_read = {f[31], mag[30:0]};
  endfunction

  function automatic logic [7:0] rd_byte(input logic [15:0] a, input stlc_state_t st, input logic [63:0] t);
    logic [2:0] i;
    logic [63:0] v;
    i = a[2:0];
    v = 64'h0;
    if (in_rng(a, STLC_SYS_TIME_ADDR, 16'h0008)) begin
      v = t;
    end else if (in_rng(a, STLC_RX_EPU_ADDR, 16'h0008)) begin
      v = st.rx_stamp;
    end else if (in_rng(a, STLC_RX_TRIG_ADDR, 16'h0004)) begin
      v = st.rx_stamp;
    end else if (in_rng(a, STLC_OFFSET_ADDR, 16'h0008)) begin
      v = st.offset;
    end else if (in_rng(a, STLC_DELAY_ADDR, 16'h0004)) begin
      v = {32'h0, st.delay};
    end else if (in_rng(a, STLC_DIFF_ADDR, 16'h0004)) begin
      v = {diff_read(st.filt), 32'h0};
    end else if (in_rng(a, STLC_START_ADDR, 16'h0002)) begin
      v = {48'h0, 1'b0, st.start};
    end else if (in_rng(a, STLC_SPD_ADDR, 16'h0002)) begin
      v = {32'h0, st.spd, 16'h0};
    end else if (a == STLC_DEPTH_ADDR) begin
      v = {28'h0, st.depth, 32'h0};
    end
    rd_byte = v[8*i +: 8];
  endfunction

  // Plain register stores and their clearing side effects
  function automatic stlc_state_t wr_reg(input stlc_state_t st, input logic [15:0] a, input logic [7:0] b);
    stlc_state_t r;
    logic [63:0] tmp;
    r = st;
    tmp = 64'h0;
    if (in_rng(a, STLC_OFFSET_ADDR, 16'h0008)) begin
      r.offset = set_byte(st.offset, a[2:0], b);
    end else if (in_rng(a, STLC_DELAY_ADDR, 16'h0004)) begin
      tmp = set_byte({32'h0, st.delay}, a[2:0], b);
      r.delay = tmp[31:0];
    end else if (in_rng(a, STLC_START_ADDR, 16'h0002)) begin
      tmp = set_byte({49'h0, st.start}, a[2:0], b);
      r.start = tmp[14:0];
      r.filt = 32'sh0;
      r.spd = 16'sh0;
      r.corr_cnt = 16'h0;
    end else if (a == STLC_DEPTH_ADDR) begin
      r.depth = b[3:0];
      r.filt = 32'sh0;
    end
    wr_reg = r;
  endfunction

  // One control loop step: mean filter, then speed counter nudge with clamp
  function automatic stlc_state_t loop_step(input stlc_state_t st, input logic [31:0] ref_t, input logic [31:0] rx);
    stlc_state_t r;
    logic signed [31:0] d;
    logic signed [31:0] err;
    logic signed [15:0] lim;
    r = st;
    d = signed'(ref_t - rx);
    err = d - st.filt;
    r.filt = st.filt + (err >>> st.depth);
    lim = signed'({1'b0, st.start} - STLC_SPD_MARGIN);
    if (d < 0) begin
      r.spd = (st.spd < lim) ? st.spd + 16'sh1 : lim;
    end else if (d > 0) begin
      r.spd = (st.spd > -lim) ? st.spd - 16'sh1 : -lim;
    end
    loop_step = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign sys_now = s.local_time + s.offset + s.drift;

  always_comb begin
    logic [15:0] spd_mag;
    logic [15:0] thr;
    logic [63:0] tmp;
    spd_mag = 16'h0;
    thr = 16'h0;
    tmp = 64'h0;
    next_s = s;
    next_s.local_time = s.local_time + STLC_TIME_STEP;

    // Smaller start or larger deviation means more frequent one-unit nudges;
    // a nudge of one against a step of eight never moves time backwards
    spd_mag = s.spd[15] ? 16'(-s.spd) : 16'(s.spd);
    thr = {1'b0, s.start} - spd_mag;
    if (s.spd != 16'sh0 && s.corr_cnt >= thr) begin
      next_s.corr_cnt = 16'h0;
      next_s.drift = s.spd[15] ? s.drift - 64'h1 : s.drift + 64'h1;
    end else begin
      next_s.corr_cnt = s.corr_cnt + 16'h1;
    end

    if (frame_i.preamble) begin
      next_s.pre_time = s.local_time;
    end
    if (frame_i.sof) begin
      next_s.sof_snap = sys_now + {32'h0, s.delay};
      next_s.net_lowb = 1'b0;
      next_s.rx_pending = 1'b0;
    end

    // Host side first so that a same-cycle network write wins
    next_s.host_rdata = 8'h00;
    if (host_i.rd) begin
      if (host_i.addr == STLC_SYS_TIME_ADDR) begin
        next_s.host_snap = sys_now;
        next_s.host_rdata = sys_now[7:0];
      end else begin
        next_s.host_rdata = rd_byte(host_i.addr, s, s.host_snap);
      end
    end
    if (host_i.wr && host_ctrl_en_i) begin
      next_s = wr_reg(next_s, host_i.addr, host_i.wdata);
      if (in_rng(host_i.addr, STLC_SYS_TIME_ADDR, 16'h0004)) begin
        tmp = set_byte({32'h0, s.host_wbuf}, host_i.addr[2:0], host_i.wdata);
        next_s.host_wbuf = tmp[31:0];
        if (host_i.addr[2:0] == STLC_SYS_LAST_WR_BYTE) begin
          next_s = loop_step(next_s, capture0_stamp_i, tmp[31:0]);
        end
      end
    end

    next_s.net_rdata = 8'h00;
    if (net_i.rd) begin
      next_s.net_rdata = rd_byte(net_i.addr, s, s.sof_snap);
    end
    if (net_i.wr) begin
      next_s = wr_reg(next_s, net_i.addr, net_i.wdata);
      if (in_rng(net_i.addr, STLC_SYS_TIME_ADDR, 16'h0004)) begin
        tmp = set_byte({32'h0, next_s.net_wbuf}, net_i.addr[2:0], net_i.wdata);
        next_s.net_wbuf = tmp[31:0];
        if (net_i.addr == STLC_SYS_TIME_ADDR) begin
          next_s.net_lowb = 1'b1;
        end
      end
      if (net_i.addr == STLC_RX_TRIG_ADDR) begin
        next_s.rx_pending = 1'b1;
      end
    end

    // Stamps commit at frame end so they cannot be read in the writing frame
    if (frame_i.eof) begin
      if (next_s.rx_pending) begin
        next_s.rx_stamp = s.pre_time;
        next_s.rx_pending = 1'b0;
      end
      if (next_s.net_lowb) begin
        next_s = loop_step(next_s, s.sof_snap[31:0], next_s.net_wbuf);
        next_s.net_lowb = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.start <= STLC_START_RESET[14:0];
      s.local_time <= STLC_TIME_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign net_rdata_o = s.net_rdata;
  assign host_rdata_o = s.host_rdata;
endmodule
`default_nettype wire

//--- stlc_frame_src.sv
// Frame source standing in for the network master: preamble, delimiter and end marks.
// Assumes cmd_i changes just after the rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none
module stlc_frame_src (
  input wire logic clk_i,
  input wire logic [1:0] cmd_i,
  output logic [2:0] frame_o
);
  import stlc_pkg::*;
  stlc_frame_t f = '0;
  assign frame_o = f;
  // Delimiter always one cycle behind the preamble mark
  always @(posedge clk_i) begin
    f.preamble <= cmd_i == 2'h1;
    f.sof <= f.preamble;
    f.eof <= cmd_i == 2'h2;
  end
endmodule
`default_nettype wire

//--- stlc_time_loop_properties.sv
// Port checker for the time loop block: read timing, snapshots and write effects.
// Assumes ce_i and both buses share clk_i; bound to every block instance.
`timescale 1ns/1ns
`default_nettype none
module stlc_time_loop_properties (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic host_ctrl_en_i,
  input wire stlc_pkg::stlc_frame_t frame_i,
  input wire stlc_pkg::stlc_bus_t net_i,
  input wire stlc_pkg::stlc_bus_t host_i,
  input wire logic [31:0] capture0_stamp_i,
  input wire logic [7:0] net_rdata_o,
  input wire logic [7:0] host_rdata_o
);
  import stlc_pkg::*;
  wire logic nrd = ce_i && net_i.rd;
  wire logic nwr = ce_i && net_i.wr;
  wire logic hrd = ce_i && host_i.rd;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_net_idle;
    ce_i && !net_i.rd |=> net_rdata_o == 8'h00;
  endproperty
  a_net_idle: assert property (p_net_idle) else $error("net read byte not idle");
  property p_host_idle;
    ce_i && !host_i.rd |=> host_rdata_o == 8'h00;
  endproperty
  a_host_idle: assert property (p_host_idle) else $error("host read byte not idle");
  property p_start_top;
    hrd && host_i.addr == STLC_START_ADDR + 16'h0001 |=> !host_rdata_o[7];
  endproperty
  a_start_top: assert property (p_start_top) else $error("start top bit not zero");
  property p_host_snap;
    (hrd && host_i.addr == 16'h0913) ##1 !(hrd && host_i.addr == STLC_SYS_TIME_ADDR) ##1
      (hrd && host_i.addr == 16'h0913) |=> host_rdata_o == $past(host_rdata_o, 2);
  endproperty
  a_host_snap: assert property (p_host_snap) else $error("host snapshot moved");
  property p_net_sof;
    (nrd && net_i.addr == 16'h0913 && !frame_i.sof) ##1 !frame_i.sof ##1
      (nrd && net_i.addr == 16'h0913 && !frame_i.sof) |=> net_rdata_o == $past(net_rdata_o, 2);
  endproperty
  a_net_sof: assert property (p_net_sof) else $error("net time moved without delimiter");
  property p_depth;
    (nwr && !host_i.wr && net_i.addr == STLC_DEPTH_ADDR) ##2 (nrd && net_i.addr == STLC_DEPTH_ADDR)
      |=> net_rdata_o == {4'h0, $past(net_i.wdata[3:0], 3)};
  endproperty
  a_depth: assert property (p_depth) else $error("depth readback wrong");
  property p_refuse;
    (hrd && host_i.addr == STLC_DELAY_ADDR) ##2 (ce_i && host_i.wr && !host_ctrl_en_i && !nwr &&
      host_i.addr == STLC_DELAY_ADDR) ##2 (hrd && host_i.addr == STLC_DELAY_ADDR)
      |=> host_rdata_o == $past(host_rdata_o, 4);
  endproperty
  a_refuse: assert property (p_refuse) else $error("host write taken while not enabled");
  property p_clear;
    (nwr && net_i.addr == STLC_START_ADDR + 16'h0001) ##2 (nrd && net_i.addr == STLC_SPD_ADDR)
      |=> net_rdata_o == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("speed diff not cleared");
  c_host_cmp: cover property (ce_i && host_i.wr && host_ctrl_en_i && host_i.addr == 16'h0913);
  c_eof: cover property (frame_i.eof);
  c_net_sys: cover property (nrd && net_i.addr == STLC_SYS_TIME_ADDR);
endmodule
bind stlc_time_loop stlc_time_loop_properties u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
  .host_ctrl_en_i(host_ctrl_en_i), .frame_i(frame_i), .net_i(net_i), .host_i(host_i),
  .capture0_stamp_i(capture0_stamp_i), .net_rdata_o(net_rdata_o), .host_rdata_o(host_rdata_o));
`default_nettype wire

//--- testbench.sv
// Self-checking bench: register access from both sides, loop steps, frame compare.
// Assumes the checker binds itself; the frame source plays the network master.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import stlc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hen = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [31:0] cap = 32'h0;
  logic [31:0] seed = 32'hD3A40CCD;
  logic [31:0] v, r;
  stlc_bus_t nb = '0;
  stlc_bus_t hb = '0;
  logic [2:0] fr;
  logic [7:0] nq, hq;
  int mismatches = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  stlc_frame_src PM (.clk_i(clk_i), .cmd_i(cmd), .frame_o(fr));
  stlc_time_loop DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .host_ctrl_en_i(hen), .frame_i(fr),
    .net_i(nb), .host_i(hb), .capture0_stamp_i(cap), .net_rdata_o(nq), .host_rdata_o(hq));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Byte accesses spaced two cycles apart, little-endian
  task automatic acc(input bit h, input bit w, input logic [15:0] a, input logic [31:0] d, input int n,
    output logic [31:0] q);
    stlc_bus_t b;
    q = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      b = '{w, !w, a + 16'(i), d[8*i +: 8]};
      if (h) hb <= b;
      else nb <= b;
      @(posedge clk_i);
      hb <= '0;
      nb <= '0;
      #1 q[8*i +: 8] = h ? hq : nq;
    end
  endtask
  task automatic frm(input logic [1:0] c);
    @(posedge clk_i);
    cmd <= c;
    @(posedge clk_i);
    cmd <= 2'h0;
    // Let the delimiter settle before the next access
    repeat (2) @(posedge clk_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    acc(1, 0, STLC_START_ADDR, 0, 2, r);
    chk(r, 32'h1000);
    acc(1, 0, STLC_DELAY_ADDR, 0, 1, r);
    acc(1, 1, STLC_DELAY_ADDR, 32'h5A, 1, r);
    acc(1, 0, STLC_DELAY_ADDR, 0, 1, r);
    chk(r, 0);
    hen <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      acc(k[0], 1, k[1] ? STLC_OFFSET_ADDR : STLC_DELAY_ADDR, seed, 4, r);
      acc(!k[0], 0, k[1] ? STLC_OFFSET_ADDR : STLC_DELAY_ADDR, 0, 4, r);
      chk(r, seed);
      acc(0, 1, STLC_DEPTH_ADDR, seed, 1, r);
      acc(0, 0, STLC_DEPTH_ADDR, 0, 1, r);
      chk(r, seed & 32'hF);
    end
    // Depth 0 so one loop step lands whole in the filter
    acc(0, 1, STLC_DEPTH_ADDR, 0, 1, r);
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      acc(0, 1, STLC_START_ADDR, 32'h80 + seed % 32'h3F80, 2, r);
      acc(0, 0, STLC_SPD_ADDR, 0, 2, r);
      chk(r, 0);
      @(posedge clk_i);
      cap <= seed;
      acc(1, 1, STLC_SYS_TIME_ADDR, k ? seed + 3 : seed - 5, 4, r);
      acc(1, 0, STLC_DIFF_ADDR, 0, 4, r);
      chk(r, k ? 32'h80000003 : 32'h5);
      acc(1, 0, STLC_SPD_ADDR, 0, 2, r);
      chk(r, k ? 32'h1 : 32'hFFFF);
    end
    acc(1, 1, STLC_START_ADDR, 32'h0100, 2, r);
    frm(2'h1);
    acc(0, 0, STLC_SYS_TIME_ADDR, 0, 4, v);
    acc(0, 0, 16'h0913, 0, 1, r);
    chk(r, v >> 24);
    acc(0, 1, STLC_RX_TRIG_ADDR, 0, 1, r);
    acc(0, 1, STLC_SYS_TIME_ADDR, v - 7, 4, r);
    frm(2'h2);
    acc(0, 0, STLC_DIFF_ADDR, 0, 4, r);
    chk(r, 32'h7);
    acc(1, 0, STLC_RX_TRIG_ADDR, 0, 4, v);
    acc(1, 0, STLC_RX_EPU_ADDR, 0, 4, r);
    chk(r, v);
    acc(1, 0, STLC_SYS_TIME_ADDR, 0, 4, v);
    acc(1, 0, 16'h0913, 0, 1, r);
    chk(r, v >> 24);
    acc(1, 0, STLC_SYS_TIME_ADDR, 0, 4, r);
    chk((r - v - 1) < 32'h400, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
